// ---- design/mpc_core.sv ----
/*
  Forty-eight channel pwm engine: command decode of a latched frame, correction
  multiplier, holding and synced width registers, 12-bit period counter, bank
  stagger, self test and a small register port.
  Assumes the frame input is held stable from before latch_blank_input rises
  until well after; latch, pwm clock and fault pins are asynchronous.
*/
//
// Operation
// - all 48 outputs stay off after reset until an enable or self test frame runs.
// - enable frame: counter becomes one on second pwm clock edge after latch.
// - without stagger, synced widths above one drive high at counter one.
// - each later pwm clock edge adds exactly one to the counter.
// - channel goes low when its synced width equals the counter.
// - disable frame zeroes counter at latch, outputs low next pwm edge unless a self test is running.
// - period is 4096 pwm clock cycles, starting where outputs rise.
// - stagger mode: banks 2, 1 and 0 start at counts 1, 1365 and 2730.
// - command 6 toggles the bank stagger flag.
// - command 7 toggles the correction off flag.
// - correction off: width stored unchanged.
// - correction on: width is value times 2/3 times (factor+32)/64.
// - factor is six bits; 32 unity, 0 half, 63 gives 1.484375.
// - corrected width rounds to nearest; 4095 with 63 gives 4052.
// - host places command in low eight bits of each frame.
// - command runs at latch rise; only upper nibble decoded.
// - sync update loads holding at latch, synced width at period start.
// - nibbles 0 to 7 select the eight commands; 1xxx unused.
// - disable frame drives all outputs low except self test pulses; its data ignored.
// - async update writes synced width at latch; next edge raises outputs whose width exceeds the counter; high ones fall only at a match.
// - correction frame loads factors from six data msbs, outputs untouched.
// - self test pulses each channel 64 pwm cycles, sampling fault input.
// - stagger flag clear after reset.
`default_nettype none
`include "mpc_map.svh"

module mpc_core (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // frame and link pins
  input wire mpc_pkg::mpc_frame_type frame_i,
  input wire logic latch_blank_input_i,
  input wire logic pwm_count_clock_i,
  input wire logic open_fault_input_i,
  // register port
  input wire mpc_pkg::mpc_bus_type bus_i,
  output logic [31:0] rdata_o,
  // pwm outputs, index 0 is channel 1
  output logic [47:0] pwm_o
);
  import mpc_pkg::*;

  function automatic logic [11:0] bank_start(input logic [1:0] bank, input logic stagger);
    logic [11:0] s;
    s = `MPC_CNT_ONE;
    if (stagger && bank == 2'h1)
      s = `MPC_BANK1_START;
    else if (stagger && bank == 2'h0)
      s = `MPC_BANK0_START;
    return s;
  endfunction

  function automatic logic [11:0] scale(input logic [11:0] v, input logic [5:0] c);
    logic [18:0] p;
    p = 19'(v) * 19'({1'b0, c} + `MPC_COR_BIAS);
    return 12'((p + `MPC_ROUND_HALF) / `MPC_DIVISOR);
  endfunction

  // pin synchronisers
  logic lat_s1_r, lat_s2_r, lat_s3_r;
  logic pck_s1_r, pck_s2_r, pck_s3_r;
  logic opn_s1_r, opn_s2_r;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      lat_s1_r <= 1'b0;
      lat_s2_r <= 1'b0;
      lat_s3_r <= 1'b0;
      pck_s1_r <= 1'b0;
      pck_s2_r <= 1'b0;
      pck_s3_r <= 1'b0;
      opn_s1_r <= 1'b1;
      opn_s2_r <= 1'b1;
    end
    else
    begin
      lat_s1_r <= latch_blank_input_i;
      lat_s2_r <= lat_s1_r;
      lat_s3_r <= lat_s2_r;
      pck_s1_r <= pwm_count_clock_i;
      pck_s2_r <= pck_s1_r;
      pck_s3_r <= pck_s2_r;
      opn_s1_r <= open_fault_input_i;
      opn_s2_r <= opn_s1_r;
    end
  end

  logic latch_rise, pwm_edge, cmd_valid;
  logic [3:0] cmd_nib;

  assign latch_rise = lat_s2_r & ~lat_s3_r;
  assign pwm_edge = pck_s2_r & ~pck_s3_r;
  assign cmd_nib = frame_i.command_field[7:4];
  assign cmd_valid = latch_rise & ~cmd_nib[3];

  // control state
  logic enabled_r, enabled_nxt;
  logic [1:0] arm_r, arm_nxt;
  logic dis_pend_r, dis_pend_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic stagger_r, stagger_nxt;
  logic corr_off_r, corr_off_nxt;
  logic [2:0] sync_pend_r, sync_pend_nxt;
  logic async_pend_r, async_pend_nxt;
  mpc_state_type state_r, state_nxt;
  logic [5:0] tst_ch_r, tst_ch_nxt;
  logic [5:0] tst_cyc_r, tst_cyc_nxt;
  logic mask_r, mask_nxt;

  always_comb
  begin
    enabled_nxt = enabled_r;
    arm_nxt = arm_r;
    dis_pend_nxt = dis_pend_r;
    cnt_nxt = cnt_r;
    stagger_nxt = stagger_r;
    corr_off_nxt = corr_off_r;
    sync_pend_nxt = sync_pend_r;
    async_pend_nxt = async_pend_r;
    state_nxt = state_r;
    tst_ch_nxt = tst_ch_r;
    tst_cyc_nxt = tst_cyc_r;
    mask_nxt = mask_r;
    if (bus_i.wr && bus_i.addr == `MPC_OFS_CTRL)
      mask_nxt = bus_i.wdata[0];
    if (pwm_edge)
    begin
      async_pend_nxt = 1'b0;
      if (dis_pend_r)
      begin
        enabled_nxt = 1'b0;
        dis_pend_nxt = 1'b0;
      end
      else if (arm_r != 2'h0)
      begin
        arm_nxt = arm_r - 2'h1;
        if (arm_r == 2'h1)
        begin
          cnt_nxt = `MPC_CNT_ONE;
          enabled_nxt = 1'b1;
        end
      end
      else if (enabled_r)
        cnt_nxt = cnt_r + 12'h001;
      for (int b = 0; b < 3; b++)
      begin
        if (enabled_nxt && cnt_nxt == bank_start(2'(b), stagger_r))
          sync_pend_nxt[b] = 1'b0;
      end
      if (state_r == ST_TEST)
      begin
        tst_cyc_nxt = tst_cyc_r + 6'h01;
        if (tst_cyc_r == `MPC_TEST_LAST_CYC)
        begin
          tst_ch_nxt = tst_ch_r + 6'h01;
          if (tst_ch_r == `MPC_TEST_LAST_CH)
            state_nxt = ST_RUN;
        end
      end
    end
    if (cmd_valid)
    begin
      case (cmd_nib)
        CMD_SYNC_UPD: sync_pend_nxt = 3'h7;
        CMD_ASYNC_UPD: async_pend_nxt = 1'b1;
        CMD_OUT_EN:
        begin
          arm_nxt = `MPC_ARM_EDGES;
          dis_pend_nxt = 1'b0;
        end
        CMD_OUT_DIS:
        begin
          cnt_nxt = `MPC_CNT_ZERO;
          dis_pend_nxt = 1'b1;
          arm_nxt = 2'h0;
        end
        CMD_SELF_TEST:
        begin
          state_nxt = ST_TEST;
          tst_ch_nxt = 6'h00;
          tst_cyc_nxt = 6'h00;
        end
        CMD_PHASE_TGL: stagger_nxt = ~stagger_r;
        CMD_CORR_TGL: corr_off_nxt = ~corr_off_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      enabled_r <= 1'b0;
      arm_r <= 2'h0;
      dis_pend_r <= 1'b0;
      cnt_r <= `MPC_CNT_ZERO;
      stagger_r <= 1'b0;
      corr_off_r <= 1'b0;
      sync_pend_r <= 3'h0;
      async_pend_r <= 1'b0;
      state_r <= ST_RUN;
      tst_ch_r <= 6'h00;
      tst_cyc_r <= 6'h00;
      mask_r <= 1'b0;
    end
    else
    begin
      enabled_r <= enabled_nxt;
      arm_r <= arm_nxt;
      dis_pend_r <= dis_pend_nxt;
      cnt_r <= cnt_nxt;
      stagger_r <= stagger_nxt;
      corr_off_r <= corr_off_nxt;
      sync_pend_r <= sync_pend_nxt;
      async_pend_r <= async_pend_nxt;
      state_r <= state_nxt;
      tst_ch_r <= tst_ch_nxt;
      tst_cyc_r <= tst_cyc_nxt;
      mask_r <= mask_nxt;
    end
  end

  // per-channel widths, factors, outputs and fault samples
  logic [47:0] fault_w;

  for (genvar i = 0; i < 48; i++)
  begin : g_chan
    localparam logic [1:0] BANK = 2'(i / 16);
    logic [5:0] cor_r, cor_nxt;
    logic [11:0] hold_r, hold_nxt;
    logic [11:0] synw_r, synw_nxt;
    logic out_r, out_nxt;
    logic flt_r, flt_nxt;
    logic [11:0] corrected, rel, width;

    always_comb
    begin
      cor_nxt = cor_r;
      hold_nxt = hold_r;
      synw_nxt = synw_r;
      out_nxt = out_r;
      flt_nxt = flt_r;
      corrected = corr_off_r ? frame_i.chan[i] : scale(frame_i.chan[i], cor_r);
      rel = cnt_nxt - bank_start(BANK, stagger_r) + `MPC_CNT_ONE;
      width = (sync_pend_r[BANK] && rel == `MPC_CNT_ONE) ? hold_r : synw_r;
      if (pwm_edge)
      begin
        // copy in step with the control clear, also while masked or testing
        if (enabled_nxt)
          synw_nxt = width;
        if (state_r == ST_TEST)
        begin
          out_nxt = (tst_ch_r == 6'(i));
          if (out_r)
            flt_nxt = opn_s2_r;
        end
        else if (dis_pend_r || !enabled_nxt || mask_r)
          out_nxt = 1'b0;
        else
        begin
          if (width == rel)
            out_nxt = 1'b0;
          else if (rel == `MPC_CNT_ONE && width != `MPC_CNT_ZERO)
            out_nxt = 1'b1;
          else if (async_pend_r && width > rel)
            out_nxt = 1'b1;
        end
      end
      if (cmd_valid)
      begin
        if (cmd_nib == CMD_SYNC_UPD || cmd_nib == CMD_ASYNC_UPD)
          hold_nxt = corrected;
        if (cmd_nib == CMD_ASYNC_UPD)
          synw_nxt = corrected;
        if (cmd_nib == CMD_CORR)
          cor_nxt = frame_i.chan[i][11:6];
      end
    end

    always_ff @(posedge mclk_i)
    begin
      if (srst_i)
      begin
        cor_r <= `MPC_COR_RESET;
        hold_r <= `MPC_CNT_ZERO;
        synw_r <= `MPC_CNT_ZERO;
        out_r <= 1'b0;
        flt_r <= 1'b0;
      end
      else
      begin
        cor_r <= cor_nxt;
        hold_r <= hold_nxt;
        synw_r <= synw_nxt;
        out_r <= out_nxt;
        flt_r <= flt_nxt;
      end
    end

    assign pwm_o[i] = out_r;
    assign fault_w[i] = flt_r;
  end

  // register port read
  logic [31:0] rdata_r, rdata_nxt;

  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        `MPC_OFS_STATUS:
        begin
          rdata_nxt[11:0] = cnt_r;
          rdata_nxt[`MPC_ST_ENABLED] = enabled_r;
          rdata_nxt[`MPC_ST_STAGGER] = stagger_r;
          rdata_nxt[`MPC_ST_CORR_OFF] = corr_off_r;
          rdata_nxt[`MPC_ST_TEST] = (state_r == ST_TEST);
          rdata_nxt[`MPC_ST_MASK] = mask_r;
        end
        `MPC_OFS_FAULT_LO: rdata_nxt = fault_w[31:0];
        `MPC_OFS_FAULT_HI: rdata_nxt[15:0] = fault_w[47:32];
        `MPC_OFS_CTRL: rdata_nxt[0] = mask_r;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end

  assign rdata_o = rdata_r;

endmodule // mpc_core

`default_nettype wire

// ---- design/mpc_map.svh ----
/*
  Offsets, reset values and counts of the multichannel pwm core.
  Assumes inclusion by bare name from the core's module.
*/
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH

// register port offsets
`define MPC_OFS_STATUS 4'h0
`define MPC_OFS_FAULT_LO 4'h4
`define MPC_OFS_FAULT_HI 4'h8
`define MPC_OFS_CTRL 4'hC

// status word fields
`define MPC_ST_ENABLED 12
`define MPC_ST_STAGGER 13
`define MPC_ST_CORR_OFF 14
`define MPC_ST_TEST 15
`define MPC_ST_MASK 16

// period counter values
`define MPC_CNT_ZERO 12'h000
`define MPC_CNT_ONE 12'h001
`define MPC_BANK1_START 12'h555
`define MPC_BANK0_START 12'hAAA

// enable waits this many pwm clock edges
`define MPC_ARM_EDGES 2'h2

// correction arithmetic: round((v * (c + 32)) / 96)
`define MPC_COR_RESET 6'h20
`define MPC_COR_BIAS 7'h20
`define MPC_ROUND_HALF 19'h00030
`define MPC_DIVISOR 19'h00060

// self test pacing
`define MPC_TEST_LAST_CYC 6'h3F
`define MPC_TEST_LAST_CH 6'h2F

`endif

// ---- design/mpc_pkg.sv ----
/*
  Types of the multichannel pwm core: commands, states and carriers.
  Assumes nothing beyond the map header.
*/
`default_nettype none

package mpc_pkg;

  typedef enum logic [3:0] {
    CMD_SYNC_UPD,
    CMD_ASYNC_UPD,
    CMD_CORR,
    CMD_OUT_EN,
    CMD_OUT_DIS,
    CMD_SELF_TEST,
    CMD_PHASE_TGL,
    CMD_CORR_TGL
  } mpc_cmd_type;

  typedef enum logic {
    ST_RUN,
    ST_TEST
  } mpc_state_type;

  // latched frame: 48 channel fields, most significant channel first, then command_field
  typedef struct packed {
    logic [47:0][11:0] chan;
    logic [7:0] command_field;
  } mpc_frame_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mpc_bus_type;

endpackage

`default_nettype wire

// ---- tb/mpc_core_chk.sv ----
/* port checker for the pwm core, bound to every mpc_core.
   assumes one clock domain and a synchronous active high reset. */
`default_nettype none
module mpc_core_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // link and bus
  input wire mpc_pkg::mpc_frame_type frame_i,
  input wire logic latch_blank_input_i,
  input wire logic pwm_count_clock_i,
  input wire logic open_fault_input_i,
  input wire mpc_pkg::mpc_bus_type bus_i,
  // outputs
  input wire logic [31:0] rdata_o,
  input wire logic [47:0] pwm_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mpc_pkg::*;
  logic lat_r, en_r, en_nxt, tst_r, tst_nxt, go;
  logic [11:0] hc_r, hc_nxt;
  logic [3:0] cmd;
  assign cmd = frame_i.command_field[7:4];
  assign go = latch_blank_input_i & ~lat_r;
  always_comb
  begin
    en_nxt = en_r | (go & (cmd == 4'h3 || cmd == 4'h5));
    tst_nxt = tst_r | (go & cmd == 4'h5);
    hc_nxt = pwm_o[0] ? hc_r + 12'h001 : 12'h000;
  end
  always_ff @(posedge mclk_i)
  begin
    lat_r <= srst_i ? 1'b0 : latch_blank_input_i;
    en_r <= srst_i ? 1'b0 : en_nxt;
    tst_r <= srst_i ? 1'b0 : tst_nxt;
    hc_r <= srst_i ? 12'h000 : hc_nxt;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_off_after_reset: assert property ($fell(srst_i) |-> pwm_o == 48'h0) else $error("on after reset");
  a_off_until_enable: assert property (!en_r |-> pwm_o == 48'h0) else $error("on before enable");
  a_change_on_edge: assert property ($changed(pwm_o) |->
    $past(pwm_count_clock_i, 2) && !$past(pwm_count_clock_i, 5)) else $error("change off pwm edge");
  a_disable_all_low: assert property ($rose(latch_blank_input_i) && cmd == 4'h4 |-> ##20 pwm_o == 48'h0)
    else $error("disable left outputs on");
  a_reserved_quiet: assert property ($rose(latch_blank_input_i) && cmd[3] && pwm_o == 48'h0 |->
    ##12 (pwm_o == 48'h0) [*8]) else $error("reserved code acted");
  a_read_idle_zero: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0) else $error("stray read data");
  a_test_one_hot: assert property (tst_r |-> $onehot0(pwm_o)) else $error("test not one hot");
  a_test_pulse_len: assert property (tst_r && $fell(pwm_o[0]) |-> hc_r == 12'h300)
    else $error("test pulse length");
endmodule // mpc_core_chk
bind mpc_core mpc_core_chk i_chk (.mclk_i(mclk_i), .srst_i(srst_i), .frame_i(frame_i),
  .latch_blank_input_i(latch_blank_input_i), .pwm_count_clock_i(pwm_count_clock_i),
  .open_fault_input_i(open_fault_input_i), .bus_i(bus_i), .rdata_o(rdata_o), .pwm_o(pwm_o));
`default_nettype wire

// ---- tb/mpc_core_test.sv ----
/* self-checking bench of the pwm core.
   assumes the host model and the bound checker. */
`default_nettype none
module mpc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mpc_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic flt = 1'b1;
  logic lat, pck;
  mpc_frame_type frm, f;
  mpc_bus_type bus = '0;
  logic [31:0] rdata, d, s;
  logic [47:0] pwm;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int c1;
  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  mpc_host i_host (.mclk_i(mclk), .frame_o(frm), .latch_o(lat), .pwm_clk_o(pck));
  mpc_core i_dut (.mclk_i(mclk), .srst_i(srst), .frame_i(frm), .latch_blank_input_i(lat),
    .pwm_count_clock_i(pck), .open_fault_input_i(flt), .bus_i(bus), .rdata_o(rdata), .pwm_o(pwm));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic wt(input int ch, input logic lvl);
    int n;
    n = 0;
    while (pwm[ch] !== lvl && n < 20000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk(pwm[ch], lvl);
  endtask
  task automatic cn(input logic [11:0] e);
    rd(4'h0);
    chk(d[11:0], e);
  endtask
  task automatic send_cmd(input logic [7:0] c);
    f.command_field = c;
    i_host.send(f);
  endtask
  task automatic t_corr;
    f = '0;
    f.chan[0] = 12'hFC0;
    f.chan[1] = 12'h800;
    f.chan[3] = 12'hFC0;
    send_cmd(8'h2A);
    f = '0;
    f.chan[0] = 12'h078;
    f.chan[1] = 12'h078;
    f.chan[2] = 12'h078;
    f.chan[3] = 12'h003;
    send_cmd(8'h10);
    chk(pwm, 48'h0);
    send_cmd(8'h30);
    wt(0, 1'b1);
    chk(pwm, 48'hF);
    cn(12'h001);
    wt(3, 1'b0);
    cn(12'h003);
    wt(2, 1'b0);
    cn(12'h028);
    wt(1, 1'b0);
    cn(12'h050);
    wt(0, 1'b0);
    cn(12'h077);
  endtask
  task automatic t_off;
    f = '0;
    send_cmd(8'h7F);
    f.chan[5] = 12'h3E8;
    send_cmd(8'h1C);
    wt(5, 1'b1);
    wt(5, 1'b0);
    cn(12'h3E8);
  endtask
  task automatic t_stag;
    f = '0;
    send_cmd(8'h6E);
    f.chan[47] = 12'h00A;
    f.chan[31] = 12'h00A;
    f.chan[15] = 12'h00A;
    send_cmd(8'h10);
    wt(31, 1'b1);
    c1 = cyc;
    cn(12'h555);
    wt(15, 1'b1);
    chk(48'(cyc - c1), 48'h3FFC);
    cn(12'hAAA);
    wt(47, 1'b1);
    chk(48'(cyc - c1), 48'h8010);
    cn(12'h001);
    f = '0;
    f.chan[47] = 12'h014;
    send_cmd(8'h05);
    wt(47, 1'b0);
    cn(12'h00A);
  endtask
  task automatic t_dis;
    f = '1;
    send_cmd(8'h4F);
    repeat (20) @(posedge mclk);
    chk(pwm, 48'h0);
    rd(4'h0);
    s = d;
    chk(d[12:0], 13'h0);
    send_cmd(8'hE3);
    rd(4'h0);
    chk(d, s);
    wr(4'hC, 32'h1);
    rd(4'h0);
    chk(d[16], 1'b1);
    wr(4'hC, 32'h0);
    rd(4'h2);
    chk(d, 32'h0);
  endtask
  task automatic t_test;
    f = '0;
    send_cmd(8'h50);
    wt(0, 1'b1);
    wt(0, 1'b0);
    c1 = cyc;
    chk(pwm, 48'h2);
    @(posedge mclk);
    flt <= 1'b0;
    wt(1, 1'b0);
    chk(48'(cyc - c1), 48'h300);
    rd(4'h4);
    chk(d[1:0], 2'h1);
  endtask
  task automatic final_report;
    $display("checks %0d, fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(4'h0);
    chk(d[14:12], 3'h0);
    t_corr;
    t_off;
    t_stag;
    t_dis;
    t_test;
    final_report;
  end
  initial
  begin
    #400000;
    fails++;
    final_report;
  end
endmodule // mpc_core_test
`default_nettype wire

// ---- tb/mpc_host.sv ----
/* host model: sends latched frames and runs the free pwm clock.
   assumes the caller gives whole frames. */
`default_nettype none
module mpc_host
  import mpc_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // link
  output mpc_frame_type frame_o,
  output logic latch_o,
  output logic pwm_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    frame_o = '0;
    latch_o = 1'b0;
    pwm_clk_o = 1'b0;
  end
  always #24 pwm_clk_o = ~pwm_clk_o;
  // gap first so a caller regains control soon after the latch
  task automatic send(input mpc_frame_type f);
    repeat (20) @(posedge mclk_i);
    frame_o <= f;
    repeat (5) @(posedge mclk_i);
    latch_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    latch_o <= 1'b0;
    repeat (5) @(posedge mclk_i);
    frame_o <= ~f;
  endtask
endmodule // mpc_host
`default_nettype wire
